// ===== tof_result_pkg.sv
// package: register offsets, carrier structs and timing constants for the flight result bank
package tof_result_pkg;

	// register offsets of the result bank
	localparam logic [6:0] OFS_CORR_MINUS_1000 = 7'h73;
	localparam logic [6:0] OFS_CORR_MINUS_250 = 7'h76;
	localparam logic [6:0] OFS_CORR_CENTER = 7'h77;
	localparam logic [6:0] OFS_CORR_PLUS_250 = 7'h78;
	localparam logic [6:0] OFS_CORR_PLUS_500 = 7'h79;
	localparam logic [6:0] OFS_CORR_PLUS_750 = 7'h7a;
	localparam logic [6:0] OFS_CORR_PLUS_1000 = 7'h7b;
	localparam logic [6:0] OFS_FREQ_OFFSET = 7'h7c;
	localparam logic [6:0] OFS_COUNT_LOW = 7'h7d;
	localparam logic [6:0] OFS_COUNT_MID = 7'h7e;
	localparam logic [6:0] OFS_COUNT_HIGH = 7'h7f;

	// every result register clears to this value
	localparam logic [7:0] RESULT_RESET = 8'h00;
	// value read back while the mode is off or the offset is unmapped
	localparam logic [7:0] READ_IDLE = 8'h00;

	// correlator tap layout
	localparam int TAP_SPACING_NS = 250;
	localparam int TAP_REACH_NS = 1000;
	localparam int TAPS_AFTER_PEAK = TAP_REACH_NS / TAP_SPACING_NS;
	localparam int TAP_COUNT = 2 * TAPS_AFTER_PEAK + 1;

	// count byte field positions
	localparam int COUNT_LOW_LSB = 0;
	localparam int COUNT_MID_LSB = 8;
	localparam int COUNT_HIGH_LSB = 16;

	// clock rates, in MHz; the 16 MHz count is a fractional enable of the system clock
	localparam int SYS_CLK_MHZ = 25;
	localparam int FLIGHT_CLK_MHZ = 16;

	// averaging shift for the frame-long offset accumulation
	localparam int FREQ_AVG_SHIFT = 2;

	// one correlator magnitude tap with its strobes
	typedef struct packed {
		logic valid;
		logic peak;
		logic [7:0] mag;
	} corr_tap_t;

	// frequency offset measurement inputs
	typedef struct packed {
		logic phr_seen;
		logic sample_valid;
		logic frame_end;
		logic [7:0] sample;
	} freq_in_t;

endpackage

// ===== flight_counter.sv
// flight time counter ticking at 16 MHz by fractional enable of the system clock
`timescale 1ns/10ps
module flight_counter #(
	parameter int WIDTH = 24
) (
	input wire logic clk_sys_i, // system clock
	input wire logic reset_i, // async reset, active high
	input wire logic start_i, // pulse: measurement begins
	input wire logic stop_i, // pulse: measurement ends
	output logic [WIDTH-1:0] count_o, // running count
	output logic running_o, // counter is running
	output logic tick_o // 16 MHz enable pulse
);

	logic [4:0] phase_q;
	logic [5:0] phase_sum;

	// phase accumulator: 16 ticks in every 25 system cycles, so the mean rate is exact
	assign phase_sum = {1'b0, phase_q} + 6'(tof_result_pkg::FLIGHT_CLK_MHZ);
	assign tick_o = (phase_sum >= 6'(tof_result_pkg::SYS_CLK_MHZ)); // [RULE14]

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			phase_q <= 5'h00;
		end else if (tick_o) begin
			phase_q <= 5'(phase_sum - 6'(tof_result_pkg::SYS_CLK_MHZ));
		end else begin
			phase_q <= phase_sum[4:0];
		end
	end

	// start restarts from zero; stop freezes the count
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			running_o <= 1'b0;
			count_o <= '0;
		end else if (start_i) begin
			running_o <= 1'b1;
			count_o <= '0;
		end else if (stop_i) begin
			running_o <= 1'b0;
		end else if (running_o && tick_o) begin
			count_o <= count_o + WIDTH'(1);
		end
	end

endmodule

// ===== tof_result_registers.sv
// read-only result bank of the time-of-flight measurement mode
//
// How it works
// (RULE1) results readable only while mode enable set
// (RULE2) first tap: magnitude 1000 ns before peak
// (RULE3) fourth tap: magnitude 250 ns before peak
// (RULE4) centre register 0x77 holds peak magnitude
// (RULE5) register 0x78 holds magnitude 250 ns after
// (RULE6) register 0x79 holds magnitude 500 ns after
// (RULE7) register 0x7a holds magnitude 750 ns after
// (RULE8) register 0x7b holds magnitude 1000 ns after
// (RULE9) all results 8-bit, read-only, reset zero
// (RULE10) frequency offset result at register 0x7c
// (RULE11) first offset estimate loaded at header detect
// (RULE12) accumulated offset presented at frame end
// (RULE13) offset is signed byte, -90 to +90 degrees
// (RULE14) flight counter clocked at 16 MHz, bytewise; here a 16-in-25 enable of the 25 MHz system clock
// (RULE15) count bits 7:0 at register 0x7d
// (RULE16) count bits 15:8 at register 0x7e
// (RULE17) count bits 23:16 at register 0x7f
// (RULE18) count bytes hold steady between measurements
`timescale 1ns/10ps
module tof_result_registers #(
	parameter int COUNT_WIDTH = 24
) (
	input wire logic clk_sys_i, // system clock, 25 MHz
	input wire logic reset_i, // async reset, active high
	input wire logic flight_meas_enable_i, // mode enable bit
	input wire tof_result_pkg::corr_tap_t corr_tap_i, // correlator tap stream, one per 250 ns
	input wire tof_result_pkg::freq_in_t freq_in_i, // frequency offset measurement inputs
	input wire logic flight_start_i, // pulse: flight measurement starts
	input wire logic flight_stop_i, // pulse: flight measurement ends
	input wire logic reg_rd_i, // register read strobe
	input wire logic [6:0] reg_addr_i, // register address
	output logic [7:0] reg_rdata_o, // read data, from flop
	output logic reg_rvalid_o, // read data valid pulse
	output logic corr_update_o, // pulse: correlator results refreshed
	output logic flight_busy_o // flight counter running
);

	localparam int NTAP = tof_result_pkg::TAP_COUNT;
	localparam int NAFTER = tof_result_pkg::TAPS_AFTER_PEAK;

	logic [7:0] line_q [NTAP];
	logic [7:0] corr_q [NTAP];
	logic pending_q;
	logic [2:0] after_cnt_q;
	logic capture_q;
	logic signed [9:0] freq_acc_q;
	logic signed [9:0] freq_step;
	logic [7:0] freq_result_q;
	logic [COUNT_WIDTH-1:0] count_run;
	logic [COUNT_WIDTH-1:0] count_q;
	logic counter_running;
	logic counter_tick;
	logic stop_seen_q;

	// address decode used by the read mux
	function automatic logic is_corr_addr(input logic [6:0] a);
		return (a >= tof_result_pkg::OFS_CORR_MINUS_1000) && (a <= tof_result_pkg::OFS_CORR_PLUS_1000);
	endfunction

	// tap delay line: newest magnitude at index 0, oldest at the far end
	generate
		for (genvar i = 0; i < NTAP; i++) begin : g_line
			always_ff @(posedge clk_sys_i or posedge reset_i) begin
				if (reset_i) begin
					line_q[i] <= tof_result_pkg::RESULT_RESET;
				end else if (corr_tap_i.valid) begin
					line_q[i] <= (i == 0) ? corr_tap_i.mag : line_q[(i == 0) ? 0 : i - 1];
				end
			end
		end
	endgenerate

	// wait for the taps that follow the peak before freezing the window
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			pending_q <= 1'b0;
			after_cnt_q <= 3'h0;
			capture_q <= 1'b0;
		end else begin
			capture_q <= 1'b0;
			if (corr_tap_i.valid && corr_tap_i.peak && flight_meas_enable_i) begin
				pending_q <= 1'b1;
				after_cnt_q <= 3'h0;
			end else if (pending_q && corr_tap_i.valid) begin
				after_cnt_q <= after_cnt_q + 3'h1;
				if (after_cnt_q == 3'(NAFTER - 1)) begin
					pending_q <= 1'b0;
					capture_q <= 1'b1;
				end
			end
			if (!flight_meas_enable_i) begin
				pending_q <= 1'b0;
			end
		end
	end

	// once four taps trail the peak, the line holds -1000..+1000 ns; index k maps to line[8-k]
	generate
		for (genvar k = 0; k < NTAP; k++) begin : g_corr
			always_ff @(posedge clk_sys_i or posedge reset_i) begin
				if (reset_i) begin
					corr_q[k] <= tof_result_pkg::RESULT_RESET; // [RULE9]
				end else if (capture_q) begin
					corr_q[k] <= line_q[NTAP - 1 - k]; // [RULE2] [RULE3] [RULE4] [RULE8]
				end
			end
		end
	endgenerate

	assign corr_update_o = capture_q;

	// averaging step: the estimate moves a quarter of the way toward each new sample
	assign freq_step = ($signed({{2{freq_in_i.sample[7]}}, freq_in_i.sample}) - freq_acc_q)
		>>> tof_result_pkg::FREQ_AVG_SHIFT;

	// offset accumulator seeded at header detect and refined over the frame
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			freq_acc_q <= 10'sh000;
		end else if (freq_in_i.phr_seen) begin
			freq_acc_q <= $signed({{2{freq_in_i.sample[7]}}, freq_in_i.sample}); // [RULE11]
		end else if (freq_in_i.sample_valid) begin
			freq_acc_q <= freq_acc_q + freq_step; // [RULE12]
		end
	end

	// offset register: a signed byte; the average of bytes always stays in byte range
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			freq_result_q <= tof_result_pkg::RESULT_RESET; // [RULE9]
		end else if (flight_meas_enable_i && freq_in_i.phr_seen) begin
			freq_result_q <= freq_in_i.sample; // [RULE11] [RULE13]
		end else if (flight_meas_enable_i && freq_in_i.frame_end) begin
			freq_result_q <= freq_acc_q[7:0]; // [RULE12] [RULE13]
		end
	end

	// 16 MHz flight counter
	flight_counter #(
		.WIDTH(COUNT_WIDTH)
	) u_counter (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.start_i(flight_start_i && flight_meas_enable_i),
		.stop_i(flight_stop_i),
		.count_o(count_run),
		.running_o(counter_running),
		.tick_o(counter_tick)
	);

	assign flight_busy_o = counter_running;

	// result bytes latch only on stop, so a byte-by-byte read between stops never tears
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			count_q <= '0; // [RULE9]
			stop_seen_q <= 1'b0;
		end else begin
			stop_seen_q <= counter_running && flight_stop_i;
			if (counter_running && flight_stop_i) begin
				count_q <= count_run; // [RULE14] [RULE18]
			end
		end
	end

	// read mux; everything reads idle while the mode is off
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= tof_result_pkg::READ_IDLE;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (!reg_rd_i) begin
				reg_rdata_o <= reg_rdata_o;
			end else if (!flight_meas_enable_i) begin
				reg_rdata_o <= tof_result_pkg::READ_IDLE; // [RULE1]
			end else if (is_corr_addr(reg_addr_i)) begin
				reg_rdata_o <= corr_q[4'(reg_addr_i - tof_result_pkg::OFS_CORR_MINUS_1000)]; // [RULE5] [RULE6] [RULE7]
			end else if (reg_addr_i == tof_result_pkg::OFS_FREQ_OFFSET) begin
				reg_rdata_o <= freq_result_q; // [RULE10]
			end else if (reg_addr_i == tof_result_pkg::OFS_COUNT_LOW) begin
				reg_rdata_o <= count_q[tof_result_pkg::COUNT_LOW_LSB +: 8]; // [RULE15]
			end else if (reg_addr_i == tof_result_pkg::OFS_COUNT_MID) begin
				reg_rdata_o <= count_q[tof_result_pkg::COUNT_MID_LSB +: 8]; // [RULE16]
			end else if (reg_addr_i == tof_result_pkg::OFS_COUNT_HIGH) begin
				reg_rdata_o <= count_q[tof_result_pkg::COUNT_HIGH_LSB +: 8]; // [RULE17]
			end else begin
				reg_rdata_o <= tof_result_pkg::READ_IDLE;
			end
		end
	end

	// checks that guard the bank's behaviour
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);

	a_mode_off_reads: assert property ( // [RULE1]
		reg_rd_i && !flight_meas_enable_i |=> reg_rvalid_o && reg_rdata_o == 8'h00)
		else $error("read with mode off returned nonzero data");

	a_center_read: assert property ( // [RULE4]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_CORR_CENTER
		|=> reg_rdata_o == $past(corr_q[4]))
		else $error("centre register read mismatch");

	a_plus1000_read: assert property ( // [RULE8]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_CORR_PLUS_1000
		|=> reg_rdata_o == $past(corr_q[8]))
		else $error("plus 1000 ns register read mismatch");

	a_peak_capture: assert property ( // [RULE4]
		capture_q |=> corr_q[4] == $past(line_q[4]) && corr_q[0] == $past(line_q[8]))
		else $error("capture did not place peak at centre");

	a_tap_timing: assert property ( // [RULE3]
		corr_tap_i.valid && corr_tap_i.peak && flight_meas_enable_i && !pending_q
		##1 (!corr_tap_i.valid && !corr_tap_i.peak)[*4]
		|-> !capture_q)
		else $error("capture fired before trailing taps arrived");

	a_freq_init: assert property ( // [RULE11]
		flight_meas_enable_i && freq_in_i.phr_seen |=> freq_result_q == $past(freq_in_i.sample))
		else $error("initial offset estimate not loaded");

	a_freq_end: assert property ( // [RULE12]
		flight_meas_enable_i && freq_in_i.frame_end && !freq_in_i.phr_seen
		|=> freq_result_q == $past(freq_acc_q[7:0]))
		else $error("accumulated offset not presented at frame end");

	a_freq_range: assert property ( // [RULE13]
		freq_acc_q <= 10'sd127 && freq_acc_q >= -10'sd128)
		else $error("offset accumulator left signed byte range");

	a_count_stable: assert property ( // [RULE18]
		!(counter_running && flight_stop_i) |=> $stable(count_q))
		else $error("count result changed outside stop");

	a_count_mid_read: assert property ( // [RULE16]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_COUNT_MID
		|=> reg_rdata_o == $past(count_q[15:8]))
		else $error("mid count byte read mismatch");

	a_count_rate: assert property ( // [RULE14]
		counter_running && !flight_start_i && !flight_stop_i && counter_tick
		|=> count_run == $past(count_run) + 24'h000001)
		else $error("counter did not advance on tick");

	a_stop_latch: assert property ( // [RULE15]
		stop_seen_q |-> count_q == $past(count_run))
		else $error("count not latched at stop");

	// read paths compare against past values: a capture or a stop may land on the read edge
	a_minus1000_read: assert property ( // [RULE2]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_CORR_MINUS_1000
		|=> reg_rdata_o == $past(corr_q[0]))
		else $error("minus 1000 ns register read mismatch");

	a_minus250_read: assert property ( // [RULE3]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_CORR_MINUS_250
		|=> reg_rdata_o == $past(corr_q[3]))
		else $error("minus 250 ns register read mismatch");

	a_plus250_read: assert property ( // [RULE5]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_CORR_PLUS_250
		|=> reg_rdata_o == $past(corr_q[5]))
		else $error("plus 250 ns register read mismatch");

	a_plus500_read: assert property ( // [RULE6]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_CORR_PLUS_500
		|=> reg_rdata_o == $past(corr_q[6]))
		else $error("plus 500 ns register read mismatch");

	a_plus750_read: assert property ( // [RULE7]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_CORR_PLUS_750
		|=> reg_rdata_o == $past(corr_q[7]))
		else $error("plus 750 ns register read mismatch");

	a_offset_read: assert property ( // [RULE10]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_FREQ_OFFSET
		|=> reg_rdata_o == $past(freq_result_q))
		else $error("offset register read mismatch");

	a_count_low_read: assert property ( // [RULE15]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_COUNT_LOW
		|=> reg_rdata_o == $past(count_q[7:0]))
		else $error("low count byte read mismatch");

	a_count_high_read: assert property ( // [RULE17]
		reg_rd_i && flight_meas_enable_i && reg_addr_i == tof_result_pkg::OFS_COUNT_HIGH
		|=> reg_rdata_o == $past(count_q[23:16]))
		else $error("high count byte read mismatch");

	a_read_valid_pulse: assert property ( // [RULE9]
		reg_rvalid_o == $past(reg_rd_i))
		else $error("read valid did not follow the strobe");

	a_unmapped_read: assert property ( // [RULE9]
		reg_rd_i && reg_addr_i < tof_result_pkg::OFS_CORR_MINUS_1000 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read returned nonzero data");

	// capture, offset and counter control
	a_arm_cancel: assert property ( // [RULE1]
		!flight_meas_enable_i |=> !pending_q)
		else $error("peak wait survived mode off");

	a_capture_pulse: assert property ( // [RULE4]
		capture_q |=> !capture_q)
		else $error("capture strobe longer than one cycle");

	a_corr_hold: assert property ( // [RULE4]
		!capture_q |=> $stable(corr_q[0]) && $stable(corr_q[4]) && $stable(corr_q[8]))
		else $error("correlator result moved without capture");

	a_freq_hold: assert property ( // [RULE12]
		!(flight_meas_enable_i && (freq_in_i.phr_seen || freq_in_i.frame_end)) |=> $stable(freq_result_q))
		else $error("offset result moved without header or frame end");

	a_busy_start: assert property ( // [RULE14]
		flight_start_i && flight_meas_enable_i |=> flight_busy_o)
		else $error("counter not running after start");

	a_start_gated: assert property ( // [RULE1]
		flight_start_i && !flight_meas_enable_i && !counter_running |=> !flight_busy_o)
		else $error("counter started with mode off");

	a_stop_ends: assert property ( // [RULE14]
		flight_stop_i && !(flight_start_i && flight_meas_enable_i) |=> !flight_busy_o)
		else $error("counter still running after stop");

	a_tick_spacing: assert property ( // [RULE14]
		!counter_tick |=> counter_tick)
		else $error("16 MHz enable skipped two cycles");

	a_count_restart: assert property ( // [RULE14]
		flight_start_i && flight_meas_enable_i |=> count_run == '0)
		else $error("count did not restart from zero");

	c_capture: cover property (capture_q);
	c_frame: cover property (freq_in_i.phr_seen ##[1:50] freq_in_i.frame_end);
	c_flight: cover property (flight_start_i ##[1:100] stop_seen_q);
	c_read_count: cover property (reg_rd_i && reg_addr_i == 7'h7f && flight_meas_enable_i);

endmodule

// ===== tof_result_registers_test.sv
// self-checking bench for the flight result register bank
`timescale 1ns/10ps
module tof_result_registers_test;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic flight_meas_enable_i = 1'b0;
	tof_result_pkg::corr_tap_t corr_tap_i = '0;
	tof_result_pkg::freq_in_t freq_in_i = '0;
	logic flight_start_i = 1'b0;
	logic flight_stop_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [6:0] reg_addr_i = 7'h00;
	logic [7:0] reg_rdata_o;
	logic reg_rvalid_o;
	logic corr_update_o;
	logic flight_busy_o;
	int fails = 0;
	int samples_checked = 0;
	logic [7:0] rd_q;
	logic upd_q;
	logic [23:0] cnt;
	logic [23:0] prev;

	// 25 MHz system clock
	always #20 clk_sys_i = ~clk_sys_i;

	tof_result_registers dut (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.flight_meas_enable_i(flight_meas_enable_i),
		.corr_tap_i(corr_tap_i),
		.freq_in_i(freq_in_i),
		.flight_start_i(flight_start_i),
		.flight_stop_i(flight_stop_i),
		.reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i),
		.reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o),
		.corr_update_o(corr_update_o),
		.flight_busy_o(flight_busy_o)
	);

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// one read: strobe for a cycle, answer sampled half a cycle after the taking edge
	task automatic rd(input logic [6:0] a);
		@(negedge clk_sys_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge clk_sys_i);
		reg_rd_i = 1'b0;
		check({23'h0, reg_rvalid_o}, 24'h1, "read valid");
		rd_q = reg_rdata_o;
	endtask

	// one correlator tap; gap stands in for the 250 ns tap spacing
	// the update pulse stands only in the cycle right after the taking edge
	task automatic tap(input logic [7:0] mag, input logic pk);
		@(negedge clk_sys_i);
		corr_tap_i = '{valid: 1'b1, peak: pk, mag: mag};
		@(negedge clk_sys_i);
		corr_tap_i = '0;
		upd_q = corr_update_o;
		repeat (4) @(negedge clk_sys_i);
	endtask

	task automatic fq(input logic phr, input logic sv, input logic fe, input logic [7:0] s);
		@(negedge clk_sys_i);
		freq_in_i = '{phr_seen: phr, sample_valid: sv, frame_end: fe, sample: s};
		@(negedge clk_sys_i);
		freq_in_i = '0;
	endtask

	// start or stop pulse of one cycle
	task automatic pulse(input logic is_start);
		@(negedge clk_sys_i);
		flight_start_i = is_start;
		flight_stop_i = ~is_start;
		@(negedge clk_sys_i);
		flight_start_i = 1'b0;
		flight_stop_i = 1'b0;
	endtask

	// bytes are read one by one, so they must not move between the reads
	task automatic rd_count();
		rd(7'h7d);
		cnt[7:0] = rd_q;
		rd(7'h7e);
		cnt[15:8] = rd_q;
		rd(7'h7f);
		cnt[23:16] = rd_q;
	endtask

	task automatic all_zero();
		for (int a = 'h73; a <= 'h7f; a++) begin
			rd(7'(a));
			check({16'h0, rd_q}, 24'h0, "reset value");
		end
	endtask

	// watchdog: the sequence needs about 1500 cycles
	initial begin
		#(40 * 10000);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end

	initial begin
		repeat (20) @(negedge clk_sys_i);
		reset_i = 1'b0;
		flight_meas_enable_i = 1'b1;
		all_zero();
		rd(7'h10);
		check({16'h0, rd_q}, 24'h0, "unmapped read");
		// eight taps ahead of the peak fill the line, four after it close the window
		for (int k = 0; k < 13; k++) begin
			tap(8'h30 + 8'(8'h11 * k), k == 8);
			check({23'h0, upd_q}, {23'h0, k == 12}, "corr update");
		end
		for (int j = 0; j < 9; j++) begin
			rd(7'h73 + 7'(j));
			check({16'h0, rd_q}, {16'h0, 8'h30 + 8'(8'h11 * (j + 4))}, "tap");
		end
		flight_meas_enable_i = 1'b0;
		rd(7'h77);
		check({16'h0, rd_q}, 24'h0, "disabled read");
		flight_meas_enable_i = 1'b1;
		// negative seed, steady samples keep the average at the seed
		fq(1'b1, 1'b0, 1'b0, 8'hd0);
		rd(7'h7c);
		check({16'h0, rd_q}, 24'hd0, "phr estimate");
		repeat (3) fq(1'b0, 1'b1, 1'b0, 8'hd0);
		fq(1'b0, 1'b0, 1'b1, 8'h00);
		rd(7'h7c);
		check({16'h0, rd_q}, 24'hd0, "frame end steady");
		// zero seed, one sample of 0x40 moves a quarter step
		fq(1'b1, 1'b0, 1'b0, 8'h00);
		fq(1'b0, 1'b1, 1'b0, 8'h40);
		fq(1'b0, 1'b0, 1'b1, 8'h00);
		rd(7'h7c);
		check({16'h0, rd_q}, 24'h10, "frame end average");
		flight_meas_enable_i = 1'b0;
		fq(1'b1, 1'b0, 1'b0, 8'h55);
		flight_meas_enable_i = 1'b1;
		rd(7'h7c);
		check({16'h0, rd_q}, 24'h10, "phr ignored off");
		// 1250 counting edges at a 16/25 rate give exactly 800 ticks whatever the phase
		pulse(1'b1);
		check({23'h0, flight_busy_o}, 24'h1, "busy after start");
		repeat (1249) @(negedge clk_sys_i);
		pulse(1'b0);
		check({23'h0, flight_busy_o}, 24'h0, "idle after stop");
		rd_count();
		check(cnt, 24'h000320, "count");
		check({8'h0, cnt[23:8]}, 24'h3, "upper bytes");
		prev = cnt;
		pulse(1'b1);
		repeat (30) @(negedge clk_sys_i);
		rd_count();
		check(cnt, prev, "hold while running");
		pulse(1'b0);
		rd_count();
		prev = cnt;
		pulse(1'b0);
		rd_count();
		check(cnt, prev, "stray stop");
		flight_meas_enable_i = 1'b0;
		pulse(1'b1);
		check({23'h0, flight_busy_o}, 24'h0, "start ignored off");
		flight_meas_enable_i = 1'b1;
		// reset in mid-measurement clears everything
		pulse(1'b1);
		repeat (5) @(negedge clk_sys_i);
		reset_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		reset_i = 1'b0;
		check({23'h0, flight_busy_o}, 24'h0, "busy after reset");
		all_zero();
		test_done();
	end
endmodule
